/* File: core/fesq_core.v */
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "fesq_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Protect write needs key bits 10b
// - Bit 3 code enable, bit 2 data
// - Config info area needs both enables
// - Status bit 8 external read allowed
// - Status bit 6 address valid flag
// - Status bit 1 unknown command flag
// - Status bit 0 last operation timeout
// - Sector erase sets 512 bytes to ones
// - Erase ignores low 9 address bits
// - Code a6h starts sector erase
// - Code 9ah programs loaded data word
// - Processor stalls while operation runs
// - Program ANDs data into old word
// - Array readable by plain memory loads
// - Eight byte read-only ID area
module fesq_core #(
  parameter        AW        = 10,
  parameter [31:0] UID_WORD0 = 32'h5a5a0001, // Arbitrary value
  parameter [31:0] UID_WORD1 = 32'ha5a50002  // Arbitrary value
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        read_free_i,
  output wire        cpu_stall_o
);

  //////////////////////////////////////////////////////////////////////////
  // States
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_FREAD = 2'b01;
  localparam [1:0] ST_ERASE = 2'b10;
  localparam [1:0] ST_PROG  = 2'b11;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [1:0]    state_q;
  reg  [6:0]    cnt_q;
  reg           ack_q;
  reg  [31:0]   dat_q;
  reg           stall_q;
  reg           code_we_q;
  reg           data_we_q;
  reg  [31:0]   addr_q;
  reg  [31:0]   wdata_q;
  reg           cmd_err_q;
  reg           tout_q;
  reg           rfree_meta_q;
  reg           rfree_q;

  // Memory port
  reg           mem_we;
  reg  [AW-1:0] mem_addr;
  reg  [31:0]   mem_wdata;
  wire [31:0]   mem_rdata;

  // Decode
  wire          req;
  wire          reg_hit;
  wire          flash_hit;
  wire [7:0]    reg_off;
  wire          tgt_high_zero;
  wire          tgt_code;
  wire          tgt_data;
  wire          tgt_info;
  wire          addr_ok;
  wire          area_en;
  wire          erase_ok;
  wire          prog_ok;
  wire          bus_id;
  wire [31:0]   id_word;
  wire [31:0]   status_word;
  wire [7:0]    protect_word;
  reg  [31:0]   reg_rdata;
  integer       i;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
  assign reg_hit   = (wb_adr_i[15:8] == `FESQ_REG_WIN);
  assign flash_hit = (wb_adr_i[15:12] == `FESQ_FLASH_WIN);
  assign reg_off   = wb_adr_i[7:0];

  //////////////////////////////////////////////////////////////////////////
  // Target area and validity
  assign tgt_high_zero = (addr_q[31:12] == 20'h00000);
  assign tgt_code = tgt_high_zero & (addr_q[11] == `FESQ_CODE_TOP1);
  assign tgt_data = tgt_high_zero & (addr_q[11:10] == `FESQ_DATA_TOP2);
  assign tgt_info = tgt_high_zero & (addr_q[11:9] == `FESQ_INFO_TOP3);

  // ID area and anything outside the array are never valid targets
  assign addr_ok = tgt_code | tgt_data | tgt_info;

  assign area_en = (tgt_code & code_we_q) |
                   (tgt_data & data_we_q) |
                   (tgt_info & code_we_q & data_we_q);

  assign erase_ok = addr_ok & area_en;
  assign prog_ok  = addr_ok & area_en &
                    (addr_q[1:0] == 2'h0);

  //////////////////////////////////////////////////////////////////////////
  // Read-only ID words
  assign bus_id  = (wb_adr_i[11:9] == `FESQ_ID_TOP3) &
                   (wb_adr_i[8:3] == `FESQ_ID_MID);
  assign id_word = wb_adr_i[`FESQ_ID_WORD_BIT] ? UID_WORD1 :
                                                 UID_WORD0;

  //////////////////////////////////////////////////////////////////////////
  // Readable register images
  assign protect_word = {`FESQ_KEY_VAL, 2'h0, code_we_q, data_we_q, 2'h0};

  assign status_word = {16'h0000, 5'h00, `FESQ_ST_RSV_VAL,
                        rfree_q,
                        1'b0,
                        addr_ok,
                        4'h0,
                        cmd_err_q,
                        tout_q};

  always @* begin
    case (reg_off)
      `FESQ_OFF_PROTECT: reg_rdata = {24'h000000, protect_word};
      `FESQ_OFF_STATUS:  reg_rdata = status_word;
      `FESQ_OFF_ADDR:    reg_rdata = addr_q;
      `FESQ_OFF_DATA:    reg_rdata = wdata_q;
      default:           reg_rdata = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Array port steering
  always @* begin
    mem_we    = 1'b0;
    mem_addr  = wb_adr_i[AW+1:2];
    mem_wdata = `FESQ_ERASED_WORD;
    case (state_q)
      ST_IDLE: begin
        if (req & reg_hit & wb_we_i & (reg_off == `FESQ_OFF_CMD)) begin
          mem_addr = addr_q[AW+1:2];
        end
      end
      ST_ERASE: begin
        mem_we    = 1'b1;
        mem_addr  = {addr_q[AW+1:`FESQ_SECT_LO], cnt_q};
        mem_wdata = `FESQ_ERASED_WORD;
      end
      ST_PROG: begin
        mem_we    = 1'b1;
        mem_addr  = addr_q[AW+1:2];
        mem_wdata = mem_rdata & wdata_q;
      end
      default: begin
        mem_we    = 1'b0;
      end
    endcase
  end

  fesq_mem #(
    .AW (AW),
    .DW (32)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Read-free strap synchroniser
  always @(posedge clk_i) begin
    if (rst_i) begin
      rfree_meta_q <= 1'b0;
      rfree_q      <= 1'b0;
    end else begin
      rfree_meta_q <= read_free_i;
      rfree_q      <= rfree_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 7'h00;
      ack_q     <= 1'b0;
      dat_q     <= 32'h00000000;
      stall_q   <= 1'b0;
      code_we_q <= 1'b0;
      data_we_q <= 1'b0;
      addr_q    <= `FESQ_ADDR_RST;
      wdata_q   <= 32'h00000000;
      cmd_err_q <= 1'b0;
      tout_q    <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req & flash_hit & ~wb_we_i) begin
            state_q <= ST_FREAD;
          end else if (req & reg_hit & wb_we_i) begin
            case (reg_off)
              `FESQ_OFF_PROTECT: begin
                ack_q <= 1'b1;
                if (wb_sel_i[0] &&
                    wb_dat_i[`FESQ_KEY_HI:`FESQ_KEY_LO] == `FESQ_KEY_VAL)
                begin
                  code_we_q <= wb_dat_i[`FESQ_CODE_WE_BIT];
                  data_we_q <= wb_dat_i[`FESQ_DATA_WE_BIT];
                end
              end
              `FESQ_OFF_ADDR: begin
                ack_q <= 1'b1;
                for (i = 0; i < 4; i = i + 1) begin
                  if (wb_sel_i[i]) begin
                    addr_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                  end
                end
              end
              `FESQ_OFF_DATA: begin
                ack_q <= 1'b1;
                for (i = 0; i < 4; i = i + 1) begin
                  if (wb_sel_i[i]) begin
                    wdata_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                  end
                end
              end
              `FESQ_OFF_CMD: begin
                if (~wb_sel_i[0]) begin
                  ack_q <= 1'b1;
                end else if (wb_dat_i[7:0] == `FESQ_CMD_ERASE) begin
                  cmd_err_q <= 1'b0;
                  if (erase_ok) begin
                    tout_q  <= 1'b0;
                    stall_q <= 1'b1;
                    cnt_q   <= 7'h00;
                    state_q <= ST_ERASE;
                  end else begin
                    tout_q  <= 1'b1;
                    ack_q   <= 1'b1;
                  end
                end else if (wb_dat_i[7:0] == `FESQ_CMD_PROG) begin
                  cmd_err_q <= 1'b0;
                  if (prog_ok) begin
                    tout_q  <= 1'b0;
                    stall_q <= 1'b1;
                    state_q <= ST_PROG;
                  end else begin
                    tout_q  <= 1'b1;
                    ack_q   <= 1'b1;
                  end
                end else begin
                  cmd_err_q <= 1'b1;
                  ack_q     <= 1'b1;
                end
              end
              default: begin
                ack_q <= 1'b1;
              end
            endcase
          end else if (req & reg_hit) begin
            dat_q <= reg_rdata;
            ack_q <= 1'b1;
          end else if (req) begin
            dat_q <= 32'h00000000;
            ack_q <= 1'b1;
          end
        end
        ST_FREAD: begin
          dat_q   <= bus_id ? id_word : mem_rdata;
          ack_q   <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_ERASE: begin
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == `FESQ_SECT_LAST) begin
            stall_q <= 1'b0;
            ack_q   <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_PROG: begin
          stall_q <= 1'b0;
          ack_q   <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_dat_o    = dat_q;
  assign wb_ack_o    = ack_q;
  assign cpu_stall_o = stall_q;

endmodule // fesq_core

/* File: common/fesq_consts.vh */
`ifndef FESQ_CONSTS_VH
`define FESQ_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets inside the register window
`define FESQ_OFF_PROTECT      8'h00
`define FESQ_OFF_STATUS       8'h04
`define FESQ_OFF_ADDR         8'h08
`define FESQ_OFF_DATA         8'h0c
`define FESQ_OFF_CMD          8'h10

// Bus windows: adr[15:8] for registers, adr[15:12] for the flash array
`define FESQ_REG_WIN          8'h00
`define FESQ_FLASH_WIN        4'h1

////////////////////////////////////////////////////////////////////////////
// Write protect register fields
`define FESQ_KEY_HI           7
`define FESQ_KEY_LO           6
`define FESQ_KEY_VAL          2'h2
`define FESQ_CODE_WE_BIT      3
`define FESQ_DATA_WE_BIT      2

// Status register fields
`define FESQ_ST_RSV_HI        10
`define FESQ_ST_RSV_LO        9
`define FESQ_ST_RSV_VAL       2'h1
`define FESQ_ST_RFREE_BIT     8
`define FESQ_ST_ADDR_OK_BIT   6
`define FESQ_ST_CMD_ERR_BIT   1
`define FESQ_ST_TOUT_BIT      0

////////////////////////////////////////////////////////////////////////////
// Command codes
`define FESQ_CMD_ERASE        8'ha6
`define FESQ_CMD_PROG         8'h9a

// Array map, 12-bit byte address space
`define FESQ_CODE_TOP1        1'h0
`define FESQ_DATA_TOP2        2'h2
`define FESQ_INFO_TOP3        3'h6
`define FESQ_ID_TOP3          3'h7
`define FESQ_ID_MID           6'h00
`define FESQ_ID_WORD_BIT      2
`define FESQ_SECT_LO          9
`define FESQ_ERASE_IGN_LO     8'h00
`define FESQ_SECT_LAST        7'h7f
`define FESQ_ERASED_WORD      32'hffffffff
// Reset target lies outside the array so the valid flag reads 0
`define FESQ_ADDR_RST         32'hffffffff

`endif

/* File: core/fesq_mem.v */
`timescale 1ns/1ns
// Flash array storage with registered read data
module fesq_mem #(
  parameter AW = 10,
  parameter DW = 32
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output wire [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  reg [DW-1:0] rdata_q;

  always @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_q <= mem_r[addr_i];
  end

  assign rdata_o = rdata_q;

endmodule // fesq_mem

/* File: dv/fesq_strap_model.sv */
`timescale 1ns/1ns
// External strap that reports whether the array is readable from outside
module fesq_strap_model #(
  parameter FREE = 1'b1
) (
  output wire read_free_o
);
  assign read_free_o = FREE;
endmodule // fesq_strap_model

/* File: dv/fesq_core_chk.sv */
`timescale 1ns/1ns
// Port checker for the flash sequencer
module fesq_core_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        read_free_i,
  input wire logic        cpu_stall_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire cmd_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 16'h0010;
  //////////////////////////////////////////////////////////////////////////
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_reg_quick: assert property ($rose(wb_stb_i) && wb_cyc_i &&
    wb_adr_i[15:8] == 8'h00 && !cmd_w |=> wb_ack_o)
    else $error("register access not answered in one cycle");
  a_status_fixed: assert property ($rose(wb_stb_i) && !wb_we_i &&
    wb_adr_i == 16'h0004 |=> wb_dat_o[15:9] == 7'h01)
    else $error("status reserved bits wrong");
  a_flash_read: assert property ($rose(wb_stb_i) && !wb_we_i &&
    wb_adr_i[15:12] == 4'h1 |=> !wb_ack_o ##1 wb_ack_o)
    else $error("flash read latency wrong");
  a_stall_no_ack: assert property (cpu_stall_o |-> !wb_ack_o)
    else $error("ack during stall");
  a_stall_end_ack: assert property ($fell(cpu_stall_o) |-> wb_ack_o)
    else $error("stall ended without ack");
  a_stall_bound: assert property (cpu_stall_o |-> ##[1:200] !cpu_stall_o)
    else $error("stall too long");
  a_erase_long: assert property ($rose(cpu_stall_o) &&
    wb_dat_i[7:0] == 8'ha6 |-> cpu_stall_o [*8])
    else $error("erase stall too short");
  a_prog_short: assert property ($rose(cpu_stall_o) &&
    wb_dat_i[7:0] == 8'h9a |=> !cpu_stall_o && wb_ack_o)
    else $error("program stall length wrong");
  a_unknown_cmd: assert property ($rose(wb_stb_i) && cmd_w && wb_sel_i[0] &&
    wb_dat_i[7:0] != 8'ha6 && wb_dat_i[7:0] != 8'h9a
    |=> wb_ack_o && !cpu_stall_o)
    else $error("unknown command stalled");
endmodule // fesq_core_chk

bind fesq_core fesq_core_chk u_chk (.*);

/* File: dv/flash_erase_program_sequencer_test.sv */
`timescale 1ns/1ns
// Bus-level test of the flash sequencer
module flash_erase_program_sequencer_test;
  localparam [31:0] UID0 = 32'h13572468; // Arbitrary value
  localparam [31:0] UID1 = 32'h24681357; // Arbitrary value
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [15:0] adr = 16'h0000;
  reg  [3:0]  sel = 4'h0;
  reg  [31:0] dat = 32'h00000000;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        read_free;
  wire        cpu_stall_o;
  integer     n_mismatch = 0;
  integer     checked = 0;
  always #5 clk_i = ~clk_i;
  fesq_strap_model #(.FREE(1'b1)) u_strap (.read_free_o(read_free));
  fesq_core #(.UID_WORD0(UID0), .UID_WORD1(UID1)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .read_free_i(read_free),
    .cpu_stall_o(cpu_stall_o));
  //////////////////////////////////////////////////////////////////////////
  // One classic cycle: hold request until ack is sampled high
  task xfer(input w, input [15:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) begin
        @(posedge clk_i);
      end
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    reg [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task rd(input [15:0] a, input [31:0] e);
    reg [31:0] r;
    begin
      xfer(1'b0, a, 32'h0, r);
      checked = checked + 1;
      if (r !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %h expected %h seen %h", a, e, r);
      end
    end
  endtask
  // Load address and run one command
  task op(input [31:0] a, input [31:0] d, input [7:0] c);
    begin
      wr(16'h0008, a);
      wr(16'h000c, d);
      wr(16'h0010, {24'h0, c});
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(16'h0004, 32'h00000300);
    rd(16'h0000, 32'h00000080);
    wr(16'h0000, 32'h0000004c);
    rd(16'h0000, 32'h00000080);
    wr(16'h0000, 32'h0000008c);
    rd(16'h0000, 32'h0000008c);
    op(32'h000000ff, 32'h0, 8'ha6);
    rd(16'h0004, 32'h00000340);
    rd(16'h1000, 32'hffffffff);
    rd(16'h11fc, 32'hffffffff);
    op(32'h00000004, 32'h0f0f1234, 8'h9a);
    rd(16'h1004, 32'h0f0f1234);
    op(32'h00000004, 32'hff00ff00, 8'h9a);
    rd(16'h1004, 32'h0f001200);
    op(32'h00000004, 32'h0, 8'h55);
    rd(16'h0004, 32'h00000342);
    rd(16'h1004, 32'h0f001200);
    wr(16'h0000, 32'h00000080);
    op(32'h00000004, 32'h0, 8'h9a);
    rd(16'h0004, 32'h00000341);
    rd(16'h1004, 32'h0f001200);
    wr(16'h0000, 32'h00000088);
    op(32'h00000c00, 32'h0, 8'ha6);
    rd(16'h0004, 32'h00000341);
    wr(16'h0000, 32'h0000008c);
    op(32'h00000c00, 32'h0, 8'ha6);
    rd(16'h0004, 32'h00000340);
    rd(16'h1c00, 32'hffffffff);
    wr(16'h0008, 32'h00000e08);
    rd(16'h0004, 32'h00000300);
    rd(16'h1e00, UID0);
    rd(16'h1e04, UID1);
    op(32'h00000e00, 32'h0, 8'ha6);
    rd(16'h0004, 32'h00000301);
    rd(16'h1e00, UID0);
    rd(16'h0020, 32'h00000000);
    end_sim;
  end
  initial begin
    #60000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule // flash_erase_program_sequencer_test
